/* rtl/csm_defines.svh */
// Constants for the code space mode control block
`ifndef CSM_DEFINES_SVH
`define CSM_DEFINES_SVH

// ----------------------------------------------------------------
// Stack bank register layout
// ----------------------------------------------------------------
`define CSM_SBR_WIDTH      4
`define CSM_MODE_BIT       3
`define CSM_BANK_MSB       1
`define CSM_BANK_LSB       0
`define CSM_SBR_RESET      4'h8

// ----------------------------------------------------------------
// Program counter and program space
// ----------------------------------------------------------------
`define CSM_PC_WIDTH       15
`define CSM_PC_TOP_BIT     14
`define CSM_COMPACT_BYTES  16'h4000
`define CSM_EXT_BYTES      16'h8000

// ----------------------------------------------------------------
// Call frames and call timing in machine cycles
// ----------------------------------------------------------------
`define CSM_PUSH_COMPACT   2'h2
`define CSM_PUSH_EXT       2'h3
`define CSM_ABS_CYC_CMP    3'h3
`define CSM_ABS_CYC_EXT    3'h4
`define CSM_FIX_CYC_CMP    3'h2
`define CSM_FIX_CYC_EXT    3'h3
`define CSM_LONG_CYC_EXT   3'h3

`endif

/* rtl/csm_pkg.sv */
// Types for the code space mode control block
package csm_pkg;

  // ----------------------------------------------------------------
  // Call kinds and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CALL_ABS,
    CALL_FIXED,
    CALL_LONG
  } csm_call_kind_type;

  typedef enum logic {
    SEQ_IDLE,
    SEQ_RUN
  } csm_seq_state_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              start;
    csm_call_kind_type kind;
  } csm_call_req_type;

  typedef struct packed {
    logic        req;
    logic [14:0] target;
  } csm_branch_req_type;

  typedef struct packed {
    logic [14:0] pc;
  } csm_pc_state_type;

  typedef struct packed {
    logic [3:0]        stackBankReg;
    csm_seq_state_type seq;
    logic [2:0]        cycleCnt;
    logic [2:0]        cycleTarget;
    logic [1:0]        pushBytes;
    logic              callDone;
    logic              insnFault;
    logic [15:0]       progBytes;
  } csm_state_type;

endpackage

/* rtl/csm_pc_counter.sv */
// Program counter with its top bit held at zero on request
`timescale 1ns/1ns
`include "csm_defines.svh"

module csm_pc_counter #(
  parameter int PC_WIDTH = 15
) (
  input  wire logic              clk,       // machine cycle clock
  input  wire logic              rst_n,     // synchronous reset, active low
  input  wire logic              load,      // load a new address
  input  wire logic [14:0]       loadAddr,  // address to load
  input  wire logic              advance,   // step by one
  input  wire logic              holdTop,   // keep the top bit at zero
  output logic      [14:0]       pc         // current address
);

  if (PC_WIDTH != `CSM_PC_WIDTH) begin : g_chk
    $error("csm_pc_counter: only a 15-bit counter is supported");
  end

  csm_pkg::csm_pc_state_type stQ;
  csm_pkg::csm_pc_state_type stD;

  always_comb begin
    stD = stQ;
    if (load) begin
      stD.pc = loadAddr;
    end else if (advance) begin
      stD.pc = 15'(stQ.pc + 15'h0001);
    end
    if (holdTop) begin
      stD.pc[`CSM_PC_TOP_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  assign pc = stQ.pc;

endmodule // csm_pc_counter

/* rtl/csm_mode_control.sv */
// Compact / extended code space mode control with call timing
//
// Contract
// - Mode bit 1 selects compact mode, 0 selects extended mode.
// - Counter is 15 bits; compact mode holds its top bit at zero.
// - Program space is 16384 bytes compact, 32768 bytes extended.
// - A call pushes 2 bytes in compact mode, 3 in extended mode.
// - Absolute call takes 3 cycles compact, 4 cycles extended.
// - Fixed-area call takes 2 cycles compact, 3 cycles extended.
// - Reset sets the mode bit, so the core starts compact.
// - The register is written as one whole nibble in one write.
// - The stack may sit in any data bank 0 to 3 in either mode.
`timescale 1ns/1ns
`include "csm_defines.svh"

module csm_mode_control (
  input  wire logic                        clk,            // machine cycle clock, 100 MHz
  input  wire logic                        rst_n,          // synchronous system reset, active low
  input  wire logic                        sbrWrite,       // nibble write strobe to the stack bank register
  input  wire logic [3:0]                  sbrWdata,       // nibble written
  input  wire csm_pkg::csm_call_req_type   callReq,        // call start and kind
  input  wire csm_pkg::csm_branch_req_type longBranch,     // long branch with 15-bit target
  input  wire logic                        pcLoad,         // ordinary program counter load
  input  wire logic [14:0]                 pcLoadAddr,     // ordinary load address
  input  wire logic                        pcAdvance,      // step the program counter
  output logic      [3:0]                  stackBankReg,   // register read value
  output logic                             compactMode,    // 1 while in compact mode
  output logic      [1:0]                  stackBank,      // data bank holding the stack
  output logic      [15:0]                 progMemBytes,   // size of addressable program space
  output logic      [14:0]                 pc,             // program counter
  output logic                             callBusy,       // call sequence in progress
  output logic                             callDone,       // one-cycle pulse after the last call cycle
  output logic      [1:0]                  stackPushBytes, // bytes pushed by the current call
  output logic                             insnFault       // one-cycle pulse on an unavailable long insn
);

  csm_pkg::csm_state_type stQ;
  csm_pkg::csm_state_type stD;
  logic                   modeNow;
  logic                   callTake;
  logic                   longCallBad;
  logic                   longBranchOk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] call_cycles(input csm_pkg::csm_call_kind_type kind, input logic cmp);
    logic [2:0] cyc;
    cyc = `CSM_LONG_CYC_EXT;
    case (kind)
      csm_pkg::CALL_ABS:   cyc = cmp ? `CSM_ABS_CYC_CMP : `CSM_ABS_CYC_EXT;
      csm_pkg::CALL_FIXED: cyc = cmp ? `CSM_FIX_CYC_CMP : `CSM_FIX_CYC_EXT;
      default:             cyc = `CSM_LONG_CYC_EXT;
    endcase
    return cyc;
  endfunction

  function automatic logic [15:0] space_bytes(input logic cmp);
    return cmp ? `CSM_COMPACT_BYTES : `CSM_EXT_BYTES;
  endfunction

  assign modeNow      = stQ.stackBankReg[`CSM_MODE_BIT];
  assign longCallBad  = callReq.start && (callReq.kind == csm_pkg::CALL_LONG) && modeNow;
  assign callTake     = callReq.start && (stQ.seq == csm_pkg::SEQ_IDLE) && !longCallBad;
  assign longBranchOk = longBranch.req && !modeNow;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    stD           = stQ;
    stD.callDone  = 1'b0;
    stD.insnFault = 1'b0;
    if (sbrWrite) begin
      stD.stackBankReg = sbrWdata;
    end
    stD.progBytes = space_bytes(stD.stackBankReg[`CSM_MODE_BIT]);
    if ((longBranch.req && modeNow) || (longCallBad && stQ.seq == csm_pkg::SEQ_IDLE)) begin
      stD.insnFault = 1'b1;
    end
    case (stQ.seq)
      csm_pkg::SEQ_IDLE: begin
        if (callTake) begin
          stD.seq         = csm_pkg::SEQ_RUN;
          stD.cycleCnt    = 3'h1;
          stD.cycleTarget = call_cycles(callReq.kind, modeNow);
          stD.pushBytes   = modeNow ? `CSM_PUSH_COMPACT : `CSM_PUSH_EXT;
        end
      end
      csm_pkg::SEQ_RUN: begin
        if (stQ.cycleCnt == stQ.cycleTarget) begin
          stD.seq      = csm_pkg::SEQ_IDLE;
          stD.callDone = 1'b1;
        end else begin
          stD.cycleCnt = 3'(stQ.cycleCnt + 3'h1);
        end
      end
      default: begin
        stD.seq = csm_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stQ              <= '0;
      stQ.stackBankReg <= `CSM_SBR_RESET;
      stQ.seq          <= csm_pkg::SEQ_IDLE;
      stQ.pushBytes    <= `CSM_PUSH_COMPACT;
      stQ.progBytes    <= `CSM_COMPACT_BYTES;
    end else begin
      stQ <= stD;
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  csm_pc_counter #(
    .PC_WIDTH (`CSM_PC_WIDTH)
  ) csm_pc_counter_i (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (longBranchOk || pcLoad),
    .loadAddr (longBranchOk ? longBranch.target : pcLoadAddr),
    .advance  (pcAdvance),
    .holdTop  (modeNow),
    .pc       (pc)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign stackBankReg   = stQ.stackBankReg;
  assign compactMode    = stQ.stackBankReg[`CSM_MODE_BIT];
  assign stackBank      = stQ.stackBankReg[`CSM_BANK_MSB:`CSM_BANK_LSB];
  assign progMemBytes   = stQ.progBytes;
  assign callBusy       = (stQ.seq == csm_pkg::SEQ_RUN);
  assign callDone       = stQ.callDone;
  assign stackPushBytes = stQ.pushBytes;
  assign insnFault      = stQ.insnFault;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_RESET_COMPACT: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n |=> (stackBankReg == 4'h8) && compactMode && !callBusy)
    else $error("reset did not enter compact mode");

  AST_MODE_FROM_WRITE: assert property (
    sbrWrite |=> compactMode == $past(sbrWdata[3]))
    else $error("mode does not follow written bit 3");

  AST_WHOLE_NIBBLE: assert property (
    sbrWrite |=> stackBankReg == $past(sbrWdata))
    else $error("nibble write not taken whole");

  AST_PC_TOP_HELD: assert property (
    compactMode && $past(rst_n) |=> !pc[14])
    else $error("counter top bit set in compact mode");

  AST_SPACE_SIZE: assert property (
    progMemBytes == (compactMode ? 16'h4000 : 16'h8000))
    else $error("program space size does not match mode");

  AST_PUSH_BYTES: assert property (
    callTake |=> stackPushBytes == ($past(compactMode) ? 2'h2 : 2'h3))
    else $error("wrong call frame size");

  AST_ABS_CMP: assert property (
    callTake && callReq.kind == csm_pkg::CALL_ABS && compactMode |=> callBusy[*3] ##1 (callDone && !callBusy))
    else $error("absolute call length wrong in compact mode");

  AST_ABS_EXT: assert property (
    callTake && callReq.kind == csm_pkg::CALL_ABS && !compactMode |=> callBusy[*4] ##1 (callDone && !callBusy))
    else $error("absolute call length wrong in extended mode");

  AST_FIX_CMP: assert property (
    callTake && callReq.kind == csm_pkg::CALL_FIXED && compactMode |=> callBusy[*2] ##1 (callDone && !callBusy))
    else $error("fixed call length wrong in compact mode");

  AST_FIX_EXT: assert property (
    callTake && callReq.kind == csm_pkg::CALL_FIXED && !compactMode |=> callBusy[*3] ##1 (callDone && !callBusy))
    else $error("fixed call length wrong in extended mode");

  AST_BANK_SELECT: assert property (
    sbrWrite |=> stackBank == $past(sbrWdata[1:0]))
    else $error("stack bank does not follow low bits");

  AST_LONG_REFUSED: assert property (
    longBranch.req && compactMode |=> insnFault && !pc[14] &&
      (pc[13:0] == ($past(pcLoad) ? $past(pcLoadAddr[13:0])
                                  : 14'($past(pc[13:0]) + {13'h0000, $past(pcAdvance)}))))
    else $error("long branch accepted in compact mode");

  AST_LONG_BRANCH_EXT: assert property (
    longBranch.req && !compactMode |=> pc == $past(longBranch.target) && !insnFault)
    else $error("long branch not taken in extended mode");

  AST_LONG_CALL_EXT: assert property (
    callTake && callReq.kind == csm_pkg::CALL_LONG |-> !compactMode ##1 callBusy[*3] ##1 (callDone && !callBusy))
    else $error("long call length wrong or taken in compact mode");

  AST_FRAME_HELD: assert property (
    callBusy |=> $stable(stackPushBytes))
    else $error("call frame size changed during a call");

  AST_LONG_CALL_REFUSED: assert property (
    callReq.start && callReq.kind == csm_pkg::CALL_LONG && compactMode && !callBusy |=> insnFault && !callBusy)
    else $error("long call accepted in compact mode");

  COV_ABS_EXT: cover property (callTake && callReq.kind == csm_pkg::CALL_ABS && !compactMode);
  COV_FIX_CMP: cover property (callTake && callReq.kind == csm_pkg::CALL_FIXED && compactMode);
  COV_TO_EXT:  cover property (compactMode ##1 !compactMode);
  COV_FAULT:   cover property (insnFault);
  COV_LONG:    cover property (callTake && callReq.kind == csm_pkg::CALL_LONG);

endmodule // csm_mode_control

/* bench/csm_mode_control_tb.sv */
// Self-checking testbench for the code space mode control block
`timescale 1ns/1ns

module csm_mode_control_tb;
  logic                        clk;
  logic                        rst_n;
  logic                        sbrWrite;
  logic [3:0]                  sbrWdata;
  csm_pkg::csm_call_req_type   callReq;
  csm_pkg::csm_branch_req_type longBranch;
  logic                        pcLoad;
  logic [14:0]                 pcLoadAddr;
  logic                        pcAdvance;
  logic [3:0]                  stackBankReg;
  logic                        compactMode;
  logic [1:0]                  stackBank;
  logic [15:0]                 progMemBytes;
  logic [14:0]                 pc;
  logic                        callBusy;
  logic                        callDone;
  logic [1:0]                  stackPushBytes;
  logic                        insnFault;
  int                          errCount;
  int                          samplesChecked;

  csm_mode_control csm_mode_control_i (
    .clk(clk), .rst_n(rst_n), .sbrWrite(sbrWrite), .sbrWdata(sbrWdata), .callReq(callReq),
    .longBranch(longBranch), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .pcAdvance(pcAdvance),
    .stackBankReg(stackBankReg), .compactMode(compactMode), .stackBank(stackBank),
    .progMemBytes(progMemBytes), .pc(pc), .callBusy(callBusy), .callDone(callDone),
    .stackPushBytes(stackPushBytes), .insnFault(insnFault)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_reg(input logic [3:0] v);
    check("stackBankReg", {12'h000, v}, {12'h000, stackBankReg});
    check("compactMode", {15'h0000, v[3]}, {15'h0000, compactMode});
    check("stackBank", {14'h0000, v[1:0]}, {14'h0000, stackBank});
    check("progMemBytes", v[3] ? 16'h4000 : 16'h8000, progMemBytes);
  endtask

  task automatic wr(input logic [3:0] v);
    @(posedge clk);
    sbrWrite <= 1'b1;
    sbrWdata <= v;
    @(posedge clk);
    sbrWrite <= 1'b0;
    #1;
  endtask

  task automatic run_call(input csm_pkg::csm_call_kind_type k, input logic [15:0] n, input logic [15:0] push);
    int cnt;
    @(posedge clk);
    callReq <= '{start: 1'b1, kind: k};
    @(posedge clk);
    callReq.start <= 1'b0;
    #1;
    cnt = 0;
    while (callBusy === 1'b1 && cnt < 10) begin
      cnt++;
      @(posedge clk);
      #1;
    end
    check("callCycles", n, cnt[15:0]);
    check("callDone", 16'h0001, {15'h0000, callDone});
    check("stackPushBytes", push, {14'h0000, stackPushBytes});
  endtask

  task automatic pc_step(input logic ld, input logic [14:0] a, input logic adv, input logic br,
                         input logic [14:0] t, input logic [15:0] exp, input logic [15:0] flt);
    @(posedge clk);
    pcLoad     <= ld;
    pcLoadAddr <= a;
    pcAdvance  <= adv;
    longBranch <= '{req: br, target: t};
    @(posedge clk);
    pcLoad         <= 1'b0;
    pcAdvance      <= 1'b0;
    longBranch.req <= 1'b0;
    #1;
    check("pc", exp, {1'b0, pc});
    check("insnFault", flt, {15'h0000, insnFault});
  endtask

  task automatic giveVerdict();
    $display("Comparisons %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #100000;
    errCount++;
    giveVerdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    errCount = 0;
    samplesChecked = 0;
    rst_n = 1'b0;
    sbrWrite = 1'b0;
    sbrWdata = 4'h0;
    callReq = '{start: 1'b0, kind: csm_pkg::CALL_ABS};
    longBranch = '{req: 1'b0, target: 15'h0000};
    pcLoad = 1'b0;
    pcLoadAddr = 15'h0000;
    pcAdvance = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check_reg(4'h8);
    check("pc", 16'h0000, {1'b0, pc});
    check("callBusy", 16'h0000, {15'h0000, callBusy});
    @(posedge clk);
    rst_n <= 1'b1;
    $display("Test reset done");

    // Every nibble, written back to back
    @(posedge clk);
    sbrWrite <= 1'b1;
    sbrWdata <= 4'h0;
    for (int v = 1; v <= 16; v++) begin
      @(posedge clk);
      if (v < 16) begin
        sbrWdata <= v[3:0];
      end else begin
        sbrWrite <= 1'b0;
      end
      #1;
      check_reg(4'(v - 1));
    end
    $display("Test register done");

    wr(4'h9);
    run_call(csm_pkg::CALL_ABS, 16'h0003, 16'h0002);
    run_call(csm_pkg::CALL_FIXED, 16'h0002, 16'h0002);
    @(posedge clk);
    callReq <= '{start: 1'b1, kind: csm_pkg::CALL_LONG};
    @(posedge clk);
    callReq.start <= 1'b0;
    #1;
    check("longCallFault", 16'h0001, {15'h0000, insnFault});
    check("longCallBusy", 16'h0000, {15'h0000, callBusy});
    @(posedge clk);
    #1;
    check("faultPulse", 16'h0000, {15'h0000, insnFault});
    wr(4'h2);
    run_call(csm_pkg::CALL_ABS, 16'h0004, 16'h0003);
    run_call(csm_pkg::CALL_FIXED, 16'h0003, 16'h0003);
    run_call(csm_pkg::CALL_LONG, 16'h0003, 16'h0003);
    $display("Test calls done");

    wr(4'hb);
    pc_step(1'b1, 15'h7fff, 1'b0, 1'b0, 15'h0000, 16'h3fff, 16'h0000);
    pc_step(1'b0, 15'h0000, 1'b1, 1'b0, 15'h0000, 16'h0000, 16'h0000);
    pc_step(1'b0, 15'h0000, 1'b0, 1'b1, 15'h7abc, 16'h0000, 16'h0001);
    wr(4'h3);
    pc_step(1'b1, 15'h7fff, 1'b0, 1'b0, 15'h0000, 16'h7fff, 16'h0000);
    pc_step(1'b0, 15'h0000, 1'b1, 1'b0, 15'h0000, 16'h0000, 16'h0000);
    pc_step(1'b0, 15'h0000, 1'b0, 1'b1, 15'h7abc, 16'h7abc, 16'h0000);
    pc_step(1'b1, 15'h1234, 1'b1, 1'b1, 15'h5555, 16'h5555, 16'h0000);
    wr(4'h8);
    pc_step(1'b0, 15'h0000, 1'b0, 1'b0, 15'h0000, 16'h1555, 16'h0000);
    $display("Test counter done");
    giveVerdict();
  end
endmodule // csm_mode_control_tb
